/* rbsc_regs.vh */
`ifndef RBSC_REGS_VH
`define RBSC_REGS_VH

// word addresses on the register port
`define RBSC_ADDR_W 16
`define RBSC_DATA_W 16
`define RBSC_CTRL1_ADDR 16'h1c28
`define RBSC_CTRL2_ADDR 16'h1c29
`define RBSC_CTRL3_ADDR 16'h1c2a
`define RBSC_CTRL4_ADDR 16'h1c2b
`define RBSC_CTRL5_ADDR 16'h1c2c
`define RBSC_LOST0_ADDR 16'h1c30
`define RBSC_LOST1_ADDR 16'h1c31
`define RBSC_LOST2_ADDR 16'h1c32
`define RBSC_READY0_ADDR 16'h1c34
`define RBSC_READY1_ADDR 16'h1c35
`define RBSC_READY2_ADDR 16'h1c36
`define RBSC_EARLY0_ADDR 16'h1c38
`define RBSC_EARLY1_ADDR 16'h1c39
`define RBSC_EARLY2_ADDR 16'h1c3a
`define RBSC_VCOUNT_ADDR 16'h1c3c
`define RBSC_VLAST_ADDR 16'h1c3d

// reset values
`define RBSC_CTRL_RST 16'hffff
`define RBSC_VCOUNT_RST 16'h0000
`define RBSC_VLAST_RST 16'h0000

// layout
`define RBSC_NUM_CTRL 5
`define RBSC_BANKS_PER_REG 8
`define RBSC_NUM_BANKS 40
`define RBSC_SUPPLY_POS 1
`define RBSC_GROUND_POS 0
`define RBSC_VLAST_VALID_POS 15
`define RBSC_VLAST_IDX_W 6

// wake delay, given in cpu clocks; this block runs on the cpu clock
`define RBSC_WAKE_MIN_CLK 10
// load value of the 4-bit wake counter, same figure as the minimum
`define RBSC_WAKE_CNT 4'ha
`define RBSC_WAKE_CNT_W 4

`endif

/* rbsc_ctrl_reg.v */
`timescale 1ns/10ps
`include "rbsc_regs.vh"

module rbsc_ctrl_reg (
	input wire clock,
	input wire sys_rst,
	input wire writeEn,
	input wire [`RBSC_DATA_W-1:0] writeData,
	output reg [`RBSC_DATA_W-1:0] value_q
);

	always @(posedge clock) begin
		if (sys_rst)
			value_q <= `RBSC_CTRL_RST;
		else if (writeEn)
			value_q <= writeData;
	end

endmodule // rbsc_ctrl_reg

/* rbsc_bank.v */
`timescale 1ns/10ps
`include "rbsc_regs.vh"

module rbsc_bank (
	input wire clock,
	input wire sys_rst,
	input wire supplyBit,
	input wire groundBit,
	input wire access,
	input wire clrLost,
	input wire clrEarly,
	output reg supplyPin_q,
	output reg groundPin_q,
	output reg ready_q,
	output reg lost_q,
	output reg early_q,
	output wire violation
);

	wire isActive;
	wire isRetain;
	wire isOff;
	reg active_q;
	reg [`RBSC_WAKE_CNT_W-1:0] wake_q;
	reg [`RBSC_WAKE_CNT_W-1:0] wake_d;

	assign isActive = supplyBit & groundBit;
	assign isRetain = supplyBit & ~groundBit;
	assign isOff = ~isActive & ~isRetain;
	// pins follow the stored mode, never an access attempt
	assign violation = access & ~active_q;

	always @* begin
		wake_d = wake_q;
		if (isActive & ~active_q)
			wake_d = `RBSC_WAKE_CNT;
		else if (~isActive)
			wake_d = {`RBSC_WAKE_CNT_W{1'b0}};
		else if (wake_q != {`RBSC_WAKE_CNT_W{1'b0}})
			wake_d = wake_q - 1'b1;
	end

	always @(posedge clock) begin
		if (sys_rst) begin
			supplyPin_q <= 1'b1;
			groundPin_q <= 1'b1;
			active_q <= 1'b1;
			wake_q <= {`RBSC_WAKE_CNT_W{1'b0}};
			ready_q <= 1'b1;
			lost_q <= 1'b0;
			early_q <= 1'b0;
		end else begin
			supplyPin_q <= isActive | isRetain;
			groundPin_q <= isActive;
			active_q <= isActive;
			wake_q <= wake_d;
			ready_q <= isActive & (wake_d == {`RBSC_WAKE_CNT_W{1'b0}});
			// set wins; retention to off loses data too
			if (violation | (isOff & supplyPin_q))
				lost_q <= 1'b1;
			else if (clrLost)
				lost_q <= 1'b0;
			if (access & active_q & ~ready_q)
				early_q <= 1'b1;
			else if (clrEarly)
				early_q <= 1'b0;
		end
	end

endmodule // rbsc_bank

/* rbsc_top.v */
// Notes on behaviour
// - each bank's power mode is chosen by a supply and a ground sleep bit
// - both set is active, supply only is retention, both clear is disabled
// - every bank is controlled on its own; other banks are untouched
// - retention keeps contents at low power while nobody accesses the bank
// - an access during retention voids the bank's contents
// - no access in retention or disabled; disabled leaks least, loses data
// - five readable and writable sleep control registers hold the bit pairs
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "rbsc_regs.vh"

module rbsc_top (
	input wire clock,
	input wire sys_rst,
	input wire [`RBSC_ADDR_W-1:0] regAddr,
	input wire [`RBSC_DATA_W-1:0] regWriteData,
	input wire regWrite,
	input wire regRead,
	input wire [`RBSC_NUM_BANKS-1:0] bankAccess,
	output reg [`RBSC_DATA_W-1:0] regReadData_q,
	output wire [`RBSC_NUM_BANKS-1:0] bankSleepSupply_q,
	output wire [`RBSC_NUM_BANKS-1:0] bankSleepGround_q,
	output wire [`RBSC_NUM_BANKS-1:0] bankReady_q
);

	localparam NB = `RBSC_NUM_BANKS;
	localparam NC = `RBSC_NUM_CTRL;
	localparam DW = `RBSC_DATA_W;
	localparam IW = `RBSC_VLAST_IDX_W;

	// which bank index sits at a bit pair; low byte holds the upper half
	function integer pairOfBank;
		input integer b;
		begin
			pairOfBank = b ^ 4;
		end
	endfunction

	// one-hot word select within a group of three status words
	function [2:0] groupSel;
		input [`RBSC_ADDR_W-1:0] addr;
		input [`RBSC_ADDR_W-1:0] base;
		begin
			groupSel = 3'h0;
			if (addr == base)
				groupSel = 3'h1;
			else if (addr == base + 16'h0001)
				groupSel = 3'h2;
			else if (addr == base + 16'h0002)
				groupSel = 3'h4;
		end
	endfunction

	wire [DW*NC-1:0] ctrlFlat;
	wire [NC-1:0] ctrlWrite;
	wire [NB-1:0] supplyBits;
	wire [NB-1:0] groundBits;
	wire [NB-1:0] lostBits;
	wire [NB-1:0] earlyBits;
	wire [NB-1:0] violBits;
	wire [47:0] lostWide;
	wire [47:0] earlyWide;
	wire [47:0] readyWide;
	wire [47:0] clrLostWide;
	wire [47:0] clrEarlyWide;
	wire [2:0] lostSel;
	wire [2:0] earlySel;
	wire [2:0] readySel;
	wire anyViol;
	reg [DW-1:0] vcount_q;
	reg [DW-1:0] vcount_d;
	reg [DW-1:0] vlast_q;
	reg [DW-1:0] vlast_d;
	reg [IW-1:0] violIdx;
	reg [DW-1:0] readMux;
	integer k;

	// control registers; bank bits only change on a write to their word
	genvar r;
	generate
		for (r = 0; r < NC; r = r + 1) begin : gCtrl
			assign ctrlWrite[r] = regWrite &
				(regAddr == `RBSC_CTRL1_ADDR + r);
			rbsc_ctrl_reg uCtrl (
				.clock(clock),
				.sys_rst(sys_rst),
				.writeEn(ctrlWrite[r]),
				.writeData(regWriteData),
				.value_q(ctrlFlat[DW*r +: DW])
			);
		end
	endgenerate

	assign lostSel = regWrite ? groupSel(regAddr, `RBSC_LOST0_ADDR) : 3'h0;
	assign earlySel = regWrite ? groupSel(regAddr, `RBSC_EARLY0_ADDR) : 3'h0;
	assign readySel = groupSel(regAddr, `RBSC_READY0_ADDR);

	// one instance per bank keeps the banks fully independent
	genvar b;
	generate
		for (b = 0; b < NB; b = b + 1) begin : gBank
			localparam integer REG = b / `RBSC_BANKS_PER_REG;
			localparam integer PAIR = pairOfBank(b % `RBSC_BANKS_PER_REG);
			localparam integer BASE = DW * REG + 2 * PAIR;
			assign supplyBits[b] =
				ctrlFlat[BASE + `RBSC_SUPPLY_POS];
			assign groundBits[b] =
				ctrlFlat[BASE + `RBSC_GROUND_POS];
			assign clrLostWide[b] =
				lostSel[b / DW] & regWriteData[b % DW];
			assign clrEarlyWide[b] =
				earlySel[b / DW] & regWriteData[b % DW];
			rbsc_bank uBank (
				.clock(clock),
				.sys_rst(sys_rst),
				.supplyBit(supplyBits[b]),
				.groundBit(groundBits[b]),
				.access(bankAccess[b]),
				.clrLost(clrLostWide[b]),
				.clrEarly(clrEarlyWide[b]),
				.supplyPin_q(bankSleepSupply_q[b]),
				.groundPin_q(bankSleepGround_q[b]),
				.ready_q(bankReady_q[b]),
				.lost_q(lostBits[b]),
				.early_q(earlyBits[b]),
				.violation(violBits[b])
			);
		end
	endgenerate

	assign clrLostWide[47:NB] = 8'h00;
	assign clrEarlyWide[47:NB] = 8'h00;
	assign lostWide = {8'h00, lostBits};
	assign earlyWide = {8'h00, earlyBits};
	assign readyWide = {8'h00, bankReady_q};
	assign anyViol = |violBits;

	// lowest numbered offending bank is recorded when several collide
	always @* begin
		violIdx = {IW{1'b0}};
		for (k = NB - 1; k >= 0; k = k - 1) begin
			if (violBits[k])
				violIdx = k[IW-1:0];
		end
	end

	// counter saturates so a flood of bad accesses cannot wrap to zero
	always @* begin
		vcount_d = vcount_q;
		if (regWrite & (regAddr == `RBSC_VCOUNT_ADDR))
			vcount_d = `RBSC_VCOUNT_RST;
		if (anyViol & (vcount_d != {DW{1'b1}}))
			vcount_d = vcount_d + 1'b1;
	end

	always @* begin
		vlast_d = vlast_q;
		if (regWrite & (regAddr == `RBSC_VLAST_ADDR))
			vlast_d = `RBSC_VLAST_RST;
		if (anyViol) begin
			vlast_d = `RBSC_VLAST_RST;
			vlast_d[`RBSC_VLAST_VALID_POS] = 1'b1;
			vlast_d[IW-1:0] = violIdx;
		end
	end

	always @(posedge clock) begin
		if (sys_rst) begin
			vcount_q <= `RBSC_VCOUNT_RST;
			vlast_q <= `RBSC_VLAST_RST;
		end else begin
			vcount_q <= vcount_d;
			vlast_q <= vlast_d;
		end
	end

	// read path; unmapped words read as zero
	always @* begin
		readMux = {DW{1'b0}};
		case (regAddr)
		`RBSC_CTRL1_ADDR: readMux = ctrlFlat[DW*0 +: DW];
		`RBSC_CTRL2_ADDR: readMux = ctrlFlat[DW*1 +: DW];
		`RBSC_CTRL3_ADDR: readMux = ctrlFlat[DW*2 +: DW];
		`RBSC_CTRL4_ADDR: readMux = ctrlFlat[DW*3 +: DW];
		`RBSC_CTRL5_ADDR: readMux = ctrlFlat[DW*4 +: DW];
		`RBSC_LOST0_ADDR: readMux = lostWide[15:0];
		`RBSC_LOST1_ADDR: readMux = lostWide[31:16];
		`RBSC_LOST2_ADDR: readMux = lostWide[47:32];
		`RBSC_EARLY0_ADDR: readMux = earlyWide[15:0];
		`RBSC_EARLY1_ADDR: readMux = earlyWide[31:16];
		`RBSC_EARLY2_ADDR: readMux = earlyWide[47:32];
		`RBSC_VCOUNT_ADDR: readMux = vcount_q;
		`RBSC_VLAST_ADDR: readMux = vlast_q;
		default: begin
			if (readySel[0])
				readMux = readyWide[15:0];
			else if (readySel[1])
				readMux = readyWide[31:16];
			else if (readySel[2])
				readMux = readyWide[47:32];
		end
		endcase
	end

	// data stand one cycle after the strobe, zero otherwise
	always @(posedge clock) begin
		if (sys_rst)
			regReadData_q <= {DW{1'b0}};
		else if (regRead)
			regReadData_q <= readMux;
		else
			regReadData_q <= {DW{1'b0}};
	end

endmodule // rbsc_top

/* rbsc_top_properties.sv */
`timescale 1ns/10ps
`include "rbsc_regs.vh"
module rbsc_top_properties (
	input wire clock,
	input wire sys_rst,
	input wire [15:0] regAddr,
	input wire [15:0] regWriteData,
	input wire regWrite,
	input wire regRead,
	input wire [39:0] bankAccess,
	input wire [15:0] regReadData_q,
	input wire [39:0] bankSleepSupply_q,
	input wire [39:0] bankSleepGround_q,
	input wire [39:0] bankReady_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	reg [15:0] shadowCtrl1_q;
	reg [3:0] upCnt_q;
	// saturates so a long-active bank never wraps back into the wait
	always @(posedge clock) begin
		if (sys_rst) begin
			shadowCtrl1_q <= 16'hffff;
			upCnt_q <= 4'hf;
		end else begin
			if (regWrite && regAddr == `RBSC_CTRL1_ADDR)
				shadowCtrl1_q <= regWriteData;
			if (!bankSleepGround_q[4])
				upCnt_q <= 4'h0;
			else if (upCnt_q != 4'hf)
				upCnt_q <= upCnt_q + 4'h1;
		end
	end
	sequence ctrl1Write;
		regWrite && regAddr == `RBSC_CTRL1_ADDR;
	endsequence
	sequence ctrl2Write;
		regWrite && regAddr == `RBSC_CTRL2_ADDR;
	endsequence
	a_ground_needs_supply: assert property (
		(bankSleepGround_q & ~bankSleepSupply_q) == 40'h0)
		else $error("ground pin high without supply pin");
	a_ready_only_active: assert property (
		(bankReady_q & ~bankSleepGround_q) == 40'h0)
		else $error("ready on a sleeping bank");
	a_read_idle_zero: assert property (
		!$past(regRead) |-> regReadData_q == 16'h0)
		else $error("read data outside read slot");
	a_ctrl_write_pins: assert property (
		ctrl1Write |-> ##2
		bankSleepSupply_q[4] == $past(regWriteData[1], 2) &&
		bankSleepGround_q[4] == $past(&regWriteData[1:0], 2))
		else $error("bank pins do not follow control bits");
	a_other_reg_stable: assert property (
		ctrl2Write |-> ##2 $stable(bankSleepSupply_q[7:0]) &&
		$stable(bankSleepGround_q[7:0]))
		else $error("bank moved by another register");
	a_ctrl_read_back: assert property (
		regRead && regAddr == `RBSC_CTRL1_ADDR |=>
		regReadData_q == shadowCtrl1_q)
		else $error("control read back wrong");
	a_unmapped_zero: assert property (
		regRead && regAddr == 16'h1c2d |=> regReadData_q == 16'h0)
		else $error("unmapped read not zero");
	a_wake_ready_late: assert property (
		bankSleepGround_q[4] && upCnt_q < 4'ha |-> !bankReady_q[4])
		else $error("ready before wake wait");
	a_wake_ready_on: assert property (
		bankSleepGround_q[4] && upCnt_q >= 4'ha |-> bankReady_q[4])
		else $error("ready late after wake");
endmodule // rbsc_top_properties

bind rbsc_top rbsc_top_properties props (.clock(clock), .sys_rst(sys_rst),
	.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
	.regRead(regRead), .bankAccess(bankAccess),
	.regReadData_q(regReadData_q), .bankSleepSupply_q(bankSleepSupply_q),
	.bankSleepGround_q(bankSleepGround_q), .bankReady_q(bankReady_q));

/* rbsc_ram_master.sv */
`timescale 1ns/10ps
module rbsc_ram_master (
	input wire clock,
	input wire [39:0] bankReady_q,
	input wire [39:0] rogue,
	output wire [39:0] bankAccess
);
	reg [39:0] accReq_q = 40'h0;
	integer seed = 22;
	always @(posedge clock) begin
		accReq_q <= {8'($random(seed)), 32'($random(seed))};
	end
	// requests gated in the same cycle, so only rogue accesses hit a bank going to sleep
	assign bankAccess = (accReq_q & bankReady_q) | rogue;
endmodule // rbsc_ram_master

/* tb_rbsc_top.sv */
`timescale 1ns/10ps
`include "rbsc_regs.vh"
module tb_rbsc_top;
	logic clock = 0, sys_rst = 1, regWrite = 0, regRead = 0;
	logic [15:0] regAddr = 0, regWriteData = 0, regReadData_q, v;
	logic [39:0] bankAccess, rogue = 0, sup, gnd, rdy;
	int num_errors = 0, comparisons = 0, seed = 22;
	int ctrlM[5];
	initial forever #10 clock = ~clock;
	rbsc_top dut (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.bankAccess(bankAccess), .regReadData_q(regReadData_q),
		.bankSleepSupply_q(sup), .bankSleepGround_q(gnd), .bankReady_q(rdy));
	rbsc_ram_master master (.clock(clock), .bankReady_q(rdy), .rogue(rogue),
		.bankAccess(bankAccess));
	task chk16(input logic [15:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t reg %h exp %h", $time, got, exp);
		end
	endtask
	task chk40(input logic [39:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t pins %h exp %h", $time, got, exp);
		end
	endtask
	task results;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wr(input logic [15:0] a, d);
		@(posedge clock);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1;
		@(posedge clock);
		regWrite <= 0;
	endtask
	task rd(input logic [15:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1;
		@(posedge clock);
		regRead <= 0;
		#1 v = regReadData_q;
	endtask
	function automatic logic [39:0] expPins(input int g);
		for (int b = 0; b < 40; b++) begin
			int p = (ctrlM[b / 8] >> (2 * ((b % 8) ^ 4))) & 3;
			expPins[b] = g ? p == 3 : p >> 1;
		end
	endfunction
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 0;
		for (int a = 0; a < 5; a++) ctrlM[a] = 'hffff;
		// first pass covers all four bit-pair codes in every register
		for (int i = 0; i < 12; i++) begin
			for (int a = 0; a < 5; a++) begin
				rd(`RBSC_CTRL1_ADDR + a);
				chk16(v, ctrlM[a][15:0]);
				ctrlM[a] = i == 0 ? 'h1b1b : i == 11 ? 'hffff : $random(seed);
				wr(`RBSC_CTRL1_ADDR + a, ctrlM[a][15:0]);
			end
			repeat (12) @(posedge clock);
			#1 chk40(sup, expPins(0));
			chk40(gnd, expPins(1));
			chk40(rdy, expPins(1));
		end
		wr(`RBSC_LOST0_ADDR, 16'hffff);
		wr(`RBSC_VCOUNT_ADDR, 16'h0);
		wr(`RBSC_VLAST_ADDR, 16'h0);
		wr(`RBSC_CTRL1_ADDR, 16'hffbf);
		repeat (20) @(posedge clock);
		rd(`RBSC_LOST0_ADDR);
		chk16(v, 16'h0);
		@(posedge clock);
		rogue <= 40'h80;
		@(posedge clock);
		rogue <= 0;
		rd(`RBSC_LOST0_ADDR);
		chk16(v, 16'h0080);
		rd(`RBSC_VCOUNT_ADDR);
		chk16(v, 16'h1);
		rd(`RBSC_VLAST_ADDR);
		chk16(v, 16'h8007);
		wr(`RBSC_VLAST_ADDR, 16'h0);
		wr(`RBSC_VCOUNT_ADDR, 16'h5);
		rd(`RBSC_VLAST_ADDR);
		chk16(v, 16'h0);
		rd(`RBSC_VCOUNT_ADDR);
		chk16(v, 16'h0);
		wr(`RBSC_CTRL1_ADDR, 16'hffff);
		@(posedge clock);
		rogue <= 40'h80;
		@(posedge clock);
		rogue <= 0;
		rd(`RBSC_EARLY0_ADDR);
		chk16(v, 16'h0080);
		wr(`RBSC_EARLY0_ADDR, 16'h0080);
		rd(`RBSC_EARLY0_ADDR);
		chk16(v, 16'h0);
		wr(`RBSC_CTRL1_ADDR, 16'h3fff);
		repeat (12) @(posedge clock);
		rd(`RBSC_LOST0_ADDR);
		chk16(v, 16'h0088);
		wr(`RBSC_READY0_ADDR, 16'h0);
		rd(`RBSC_READY0_ADDR);
		chk16(v, 16'hfff7);
		rd(16'h1c2d);
		chk16(v, 16'h0);
		@(posedge clock);
		sys_rst <= 1;
		repeat (2) @(posedge clock);
		sys_rst <= 0;
		rd(`RBSC_CTRL1_ADDR);
		chk16(v, 16'hffff);
		results;
	end
	initial begin
		#200000;
		num_errors++;
		results;
	end
endmodule // tb_rbsc_top
